/* File: inc/tve_pkg.sv */
// constants shared by the timestamp and value encoder
// assumes one 100 MHz clock and a synchronous active-high reset

package tve_pkg;

  // ************************************************************
  // bus shape
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ************************************************************
  // register indices (word addresses on the plain port)
  // ************************************************************
  localparam logic [7:0] REG_CNT_BASE = 8'h00; // base-10000 counter, 4 words
  localparam logic [7:0] REG_XTS_BASE = 8'h04; // extended timestamp, 4 words
  localparam logic [7:0] REG_STS_BASE = 8'h08; // standard timestamp, 4 words
  localparam logic [7:0] REG_QUAL = 8'h0C; // standard timestamp quality
  localparam logic [7:0] REG_BITQ_BASE = 8'h0D; // validity/status word pairs
  localparam logic [7:0] REG_CTRL = 8'h11; // control, read/write
  localparam logic [7:0] REG_STAT = 8'h12; // block status, read only

  localparam int CNT_WORDS = 4;
  localparam int XTS_WORDS = 4;
  localparam int STS_WORDS = 4;
  localparam int STAT_PAIRS = 2;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int XTS_DAY_LSB = 0;
  localparam int XTS_MONTH_LSB = 8;
  localparam int XTS_BAD_BIT = 15;
  localparam int XTS_HOUR_LSB = 0;
  localparam int XTS_YEAR_LSB = 8;
  localparam int XTS_SEC_LSB = 0;
  localparam int XTS_MIN_LSB = 8;
  localparam int STS_YEAR_LSB = 0;
  localparam int STS_DAY_LSB = 0;
  localparam int STS_MONTH_LSB = 8;
  localparam int STS_MIN_LSB = 0;
  localparam int STS_HOUR_LSB = 8;
  localparam int QUAL_EXT_BIT = 12;
  localparam int QUAL_SYNC_BIT = 13;
  localparam int QUAL_SET_BIT = 14;

  localparam int CTRL_FORCE_BAD_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int CTRL_CLR_SYNC_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SET_BIT = 1;
  localparam int STAT_SYNC_BIT = 2;
  localparam int STAT_OVF_BIT = 3;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ************************************************************
  // arithmetic constants
  // ************************************************************
  localparam logic [11:0] YEAR_BASE_X = 12'h076C; // 1900
  localparam logic [11:0] YEAR_BASE_S = 12'h07D0; // 2000
  localparam logic [15:0] MS_PER_SEC = 16'h03E8; // 1000
  localparam logic [13:0] RADIX = 14'h2710; // 10000

  // ************************************************************
  // counter conversion states
  // ************************************************************
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_RUN = 2'b01,
    CV_PUBLISH = 2'b10
  } tve_conv_t;

endpackage

/* File: core/tve_div10k.sv */
// bit-serial divider by ten thousand for the counter formatter
// assumes start is only honoured while idle; one quotient bit per clock

module tve_div10k
  import tve_pkg::*;
#(
  parameter int W = 48
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  output logic busy,
  output logic done,
  output logic [W-1:0] quotient,
  output logic [13:0] remainder
);

  localparam int CW = $clog2(W + 1);

  logic [W-1:0] work_q;
  logic [14:0] rem_q;
  logic [CW-1:0] cnt_q;
  logic done_q;

  // ************************************************************
  // restoring step: shift one dividend bit into the remainder
  // ************************************************************
  wire [14:0] trial = {rem_q[13:0], work_q[W-1]};
  wire fits = trial >= {1'b0, RADIX};
  wire [14:0] trial_sub = trial - {1'b0, RADIX};
  wire idle = cnt_q == '0;

  // quotient bits replace dividend bits as they shift out
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      work_q <= '0;
      rem_q <= '0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= cnt_q == CW'(1);
      if (start && idle) begin
        work_q <= dividend;
        rem_q <= '0;
        cnt_q <= CW'(W);
      end else if (!idle) begin
        work_q <= {work_q[W-2:0], fits};
        rem_q <= fits ? trial_sub : trial;
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end

  assign busy = !idle;
  assign done = done_q;
  assign quotient = work_q;
  assign remainder = rem_q[13:0];

endmodule

/* File: core/tve_bitq_pair.sv */
// one validity word and the status word that follows it
// assumes the status source presents bit-aligned validity flags

module tve_bitq_pair
  import tve_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] valid_i,
  input wire logic [W-1:0] status_i,
  output logic [W-1:0] valid_word,
  output logic [W-1:0] status_word
);

  logic [W-1:0] valid_q;
  logic [W-1:0] status_q;

  // ************************************************************
  // register both words; a status bit without validity reads 0
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      valid_q <= '0;
      status_q <= '0;
    end else begin
      valid_q <= valid_i;
      status_q <= status_i & valid_i;
    end
  end

  assign valid_word = valid_q;
  assign status_word = status_q;

endmodule

/* File: core/tve_top.sv */
// timestamp and value encoder: formats a signed counter and the
// wall-clock time into 16-bit words that a register client reads
// assumes calendar inputs are synchronous and already in range

module tve_top
  import tve_pkg::*;
#(
  parameter int CNT_W = 48
) (
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [DATA_W-1:0] bus_rdata,
  // value to format as a base-10000 counter
  input wire logic signed [CNT_W-1:0] counter_value,
  // calendar time from the device clock
  input wire logic [11:0] year_in,
  input wire logic [3:0] month_in,
  input wire logic [4:0] day_in,
  input wire logic [4:0] hour_in,
  input wire logic [5:0] minute_in,
  input wire logic [5:0] second_in,
  input wire logic [9:0] msec_in,
  // time quality events
  input wire logic time_set_pulse,
  input wire logic sync_pulse,
  input wire logic ext_sync_level,
  // bit-enumerated status with validity
  input wire logic [STAT_PAIRS*DATA_W-1:0] status_valid_in,
  input wire logic [STAT_PAIRS*DATA_W-1:0] status_bits_in,
  output logic time_doubtful
);

  // ************************************************************
  // control register and time quality flags
  // ************************************************************
  logic [DATA_W-1:0] ctrl_q;
  logic time_set_q;
  logic synced_q;

  wire ctrl_hit = bus_wr && (bus_addr == REG_CTRL);
  wire clr_sync = ctrl_hit && bus_wdata[CTRL_CLR_SYNC_BIT];
  wire force_bad = ctrl_q[CTRL_FORCE_BAD_BIT];
  wire hold_cnt = ctrl_q[CTRL_HOLD_BIT];

  // clear-on-write bit is a pulse and is not stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_hit) begin
      ctrl_q <= bus_wdata & ~(DATA_W'(1) << CTRL_CLR_SYNC_BIT);
    end
  end

  // reset stands for power loss: time unset and unsynchronised
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      time_set_q <= 1'b0;
      synced_q <= 1'b0;
    end else begin
      if (time_set_pulse) begin
        time_set_q <= 1'b1;
      end
      if (sync_pulse) begin
        synced_q <= 1'b1; // set wins over a clear in the same cycle
      end else if (clr_sync) begin
        synced_q <= 1'b0;
      end
    end
  end

  // doubtful whenever unset, unsynchronised, or forced by software
  wire bad_time = !time_set_q || !synced_q || force_bad;

  // ************************************************************
  // timestamp field arithmetic
  // ************************************************************
  wire [11:0] year_x_full = year_in - YEAR_BASE_X;
  wire [7:0] year_x = year_x_full[7:0];
  wire year_s_ok = year_in >= YEAR_BASE_S;
  wire [11:0] year_s_full = year_in - YEAR_BASE_S;
  wire [6:0] year_s = year_s_ok ? year_s_full[6:0] : 7'h00;
  wire [15:0] msec_x = 16'(msec_in);
  wire [15:0] msec_s = 16'(16'(second_in) * MS_PER_SEC + 16'(msec_in));

  // ************************************************************
  // word assembly; every bit not named is zero
  // ************************************************************
  logic [DATA_W-1:0] xts_d [XTS_WORDS];
  logic [DATA_W-1:0] sts_d [STS_WORDS];
  logic [DATA_W-1:0] qual_d;

  always_comb begin
    xts_d[0] = WORD_ZERO;
    xts_d[0][XTS_DAY_LSB +: 8] = 8'(day_in);
    xts_d[0][XTS_MONTH_LSB +: 7] = 7'(month_in);
    xts_d[0][XTS_BAD_BIT] = bad_time;
    xts_d[1] = WORD_ZERO;
    xts_d[1][XTS_HOUR_LSB +: 8] = 8'(hour_in);
    xts_d[1][XTS_YEAR_LSB +: 8] = year_x;
    xts_d[2] = WORD_ZERO;
    xts_d[2][XTS_SEC_LSB +: 8] = 8'(second_in);
    xts_d[2][XTS_MIN_LSB +: 8] = 8'(minute_in);
    xts_d[3] = msec_x;
  end

  always_comb begin
    sts_d[0] = WORD_ZERO;
    sts_d[0][STS_YEAR_LSB +: 7] = year_s;
    sts_d[1] = WORD_ZERO;
    sts_d[1][STS_DAY_LSB +: 5] = day_in;
    sts_d[1][STS_MONTH_LSB +: 4] = month_in;
    sts_d[2] = WORD_ZERO;
    sts_d[2][STS_MIN_LSB +: 6] = minute_in;
    sts_d[2][STS_HOUR_LSB +: 5] = hour_in;
    sts_d[3] = msec_s;
    qual_d = WORD_ZERO;
    qual_d[QUAL_EXT_BIT] = ext_sync_level;
    qual_d[QUAL_SYNC_BIT] = synced_q;
    qual_d[QUAL_SET_BIT] = time_set_q && !force_bad;
  end

  // ************************************************************
  // timestamp word registers
  // ************************************************************
  logic [DATA_W-1:0] xts_q [XTS_WORDS];
  logic [DATA_W-1:0] sts_q [STS_WORDS];
  logic [DATA_W-1:0] qual_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < XTS_WORDS; i++) begin
        xts_q[i] <= WORD_ZERO;
        sts_q[i] <= WORD_ZERO;
      end
      qual_q <= WORD_ZERO;
    end else begin
      xts_q <= xts_d;
      sts_q <= sts_d;
      qual_q <= qual_d;
    end
  end

  assign time_doubtful = xts_q[0][XTS_BAD_BIT];

  // ************************************************************
  // base-10000 counter: sign and magnitude, then digit by digit
  // ************************************************************
  localparam int IDX_W = $clog2(CNT_WORDS);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(CNT_WORDS - 1);

  tve_conv_t state_q;
  tve_conv_t state_d;
  logic [IDX_W-1:0] idx_q;
  logic neg_q;
  logic ovf_q;
  logic [DATA_W-1:0] digit_q [CNT_WORDS];
  logic [DATA_W-1:0] cnt_q [CNT_WORDS];

  logic div_busy;
  logic div_done;
  logic [CNT_W-1:0] div_quot;
  logic [13:0] div_rem;

  wire cnt_neg = counter_value[CNT_W-1];
  wire [CNT_W-1:0] cnt_mag = cnt_neg ? CNT_W'(-counter_value) : CNT_W'(counter_value);
  wire more_digits = div_done && (idx_q != IDX_LAST);
  wire div_start = (state_q == CV_IDLE) || (state_q == CV_RUN && more_digits);
  wire [CNT_W-1:0] div_in = (state_q == CV_IDLE) ? cnt_mag : div_quot;
  wire [15:0] rem_pos = 16'(div_rem);
  wire [15:0] rem_word = neg_q ? 16'(-rem_pos) : rem_pos;

  tve_div10k #(
    .W(CNT_W)
  ) u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(div_start),
    .dividend(div_in),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_quot),
    .remainder(div_rem)
  );

  // conversion sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      CV_IDLE: begin
        if (!div_busy) begin
          state_d = CV_RUN;
        end
      end
      CV_RUN: begin
        if (div_done && idx_q == IDX_LAST) begin
          state_d = CV_PUBLISH;
        end
      end
      CV_PUBLISH: begin
        state_d = CV_IDLE;
      end
      default: begin
        state_d = CV_IDLE;
      end
    endcase
  end

  // lowest digit is stored first, at the lowest word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= CV_IDLE;
      idx_q <= '0;
      neg_q <= 1'b0;
      for (int i = 0; i < CNT_WORDS; i++) begin
        digit_q[i] <= WORD_ZERO;
      end
    end else begin
      state_q <= state_d;
      if (state_q == CV_IDLE) begin
        neg_q <= cnt_neg;
        idx_q <= '0;
      end else if (state_q == CV_RUN && div_done) begin
        digit_q[idx_q] <= rem_word;
        idx_q <= idx_q + IDX_W'(1);
      end
    end
  end

  // whole value is published at once so words never mix samples
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
      for (int i = 0; i < CNT_WORDS; i++) begin
        cnt_q[i] <= WORD_ZERO;
      end
    end else if (state_q == CV_PUBLISH && !hold_cnt) begin
      cnt_q <= digit_q;
      ovf_q <= div_quot != '0;
    end
  end

  // ************************************************************
  // validity and status word pairs
  // ************************************************************
  logic [DATA_W-1:0] bitq_word [2*STAT_PAIRS];

  for (genvar g = 0; g < STAT_PAIRS; g++) begin : g_pair
    tve_bitq_pair #(
      .W(DATA_W)
    ) u_pair (
      .sys_clk(sys_clk),
      .rst(rst),
      .valid_i(status_valid_in[g*DATA_W +: DATA_W]),
      .status_i(status_bits_in[g*DATA_W +: DATA_W]),
      .valid_word(bitq_word[2*g]),
      .status_word(bitq_word[2*g+1])
    );
  end

  // ************************************************************
  // read decode and read data register
  // ************************************************************
  wire [ADDR_W-1:0] off_cnt = bus_addr - REG_CNT_BASE;
  wire [ADDR_W-1:0] off_xts = bus_addr - REG_XTS_BASE;
  wire [ADDR_W-1:0] off_sts = bus_addr - REG_STS_BASE;
  wire [ADDR_W-1:0] off_bitq = bus_addr - REG_BITQ_BASE;
  wire hit_cnt = off_cnt < ADDR_W'(CNT_WORDS);
  wire hit_xts = off_xts < ADDR_W'(XTS_WORDS);
  wire hit_sts = off_sts < ADDR_W'(STS_WORDS);
  wire hit_bitq = off_bitq < ADDR_W'(2 * STAT_PAIRS);

  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_q;

  always_comb begin
    stat_word = WORD_ZERO;
    stat_word[STAT_BUSY_BIT] = state_q != CV_IDLE;
    stat_word[STAT_SET_BIT] = time_set_q;
    stat_word[STAT_SYNC_BIT] = synced_q;
    stat_word[STAT_OVF_BIT] = ovf_q;
  end

  // unmapped addresses read as zero
  always_comb begin
    rd_mux = WORD_ZERO;
    if (hit_cnt) begin
      rd_mux = cnt_q[off_cnt[IDX_W-1:0]];
    end else if (hit_xts) begin
      rd_mux = xts_q[off_xts[1:0]];
    end else if (hit_sts) begin
      rd_mux = sts_q[off_sts[1:0]];
    end else if (bus_addr == REG_QUAL) begin
      rd_mux = qual_q;
    end else if (hit_bitq) begin
      rd_mux = bitq_word[off_bitq[$clog2(2*STAT_PAIRS)-1:0]];
    end else if (bus_addr == REG_CTRL) begin
      rd_mux = ctrl_q;
    end else if (bus_addr == REG_STAT) begin
      rd_mux = stat_word;
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= WORD_ZERO;
    end else begin
      rdata_q <= bus_rd ? rd_mux : WORD_ZERO;
    end
  end

  assign bus_rdata = rdata_q;

endmodule

/* File: testbench/tve_top_monitor.sv */
// checker for the encoder's register port
// assumes it is bound to tve_top; reads come with calendar inputs held
module tve_mon
  import tve_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic bus_rd,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic [11:0] year_in,
  input wire logic [3:0] month_in,
  input wire logic [4:0] day_in,
  input wire logic [4:0] hour_in,
  input wire logic [5:0] minute_in,
  input wire logic [5:0] second_in,
  input wire logic [9:0] msec_in,
  input wire logic ext_sync_level,
  input wire logic [STAT_PAIRS*DATA_W-1:0] status_valid_in,
  input wire logic [STAT_PAIRS*DATA_W-1:0] status_bits_in,
  input wire logic time_doubtful
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****
  // expected words
  // ****
  wire logic [11:0] yr_x = year_in - YEAR_BASE_X;
  wire logic [11:0] yr_s = year_in - YEAR_BASE_S;
  wire logic [14:0] w04 = {3'h0, month_in, 3'h0, day_in};
  wire logic [15:0] w05 = {yr_x[7:0], 3'h0, hour_in};
  wire logic [15:0] w06 = {2'h0, minute_in, 2'h0, second_in};
  wire logic [15:0] w08 = (year_in < YEAR_BASE_S) ? WORD_ZERO : {9'h000, yr_s[6:0]};
  wire logic [15:0] w0b = 16'(second_in) * MS_PER_SEC + 16'(msec_in);
  wire logic [15:0] st0 = status_bits_in[15:0] & status_valid_in[15:0];
  // ****
  // assertions
  // ****
  property p_idle; !bus_rd |=> bus_rdata == WORD_ZERO; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero when idle");
  property p_range; bus_rd && bus_addr < REG_XTS_BASE |=>
    $signed(bus_rdata) >= -16'sh270F && $signed(bus_rdata) <= 16'sh270F; endproperty
  a_range: assert property (p_range) else $error("counter word out of range");
  property p_w04; bus_rd && bus_addr == REG_XTS_BASE && $stable(w04) |=>
    bus_rdata[14:0] == $past(w04); endproperty
  a_w04: assert property (p_w04) else $error("day/month word wrong");
  property p_w05; bus_rd && bus_addr == 8'h05 && $stable(w05) |=> bus_rdata == $past(w05);
  endproperty
  a_w05: assert property (p_w05) else $error("hour/year word wrong");
  property p_w06; bus_rd && bus_addr == 8'h06 && $stable(w06) |=> bus_rdata == $past(w06);
  endproperty
  a_w06: assert property (p_w06) else $error("second/minute word wrong");
  property p_w08; bus_rd && bus_addr == REG_STS_BASE && $stable(w08) |=>
    bus_rdata == $past(w08); endproperty
  a_w08: assert property (p_w08) else $error("standard year word wrong");
  property p_w0b; bus_rd && bus_addr == 8'h0B && $stable(w0b) |=> bus_rdata == $past(w0b);
  endproperty
  a_w0b: assert property (p_w0b) else $error("standard msec word wrong");
  property p_qual; bus_rd && bus_addr == REG_QUAL && $stable(ext_sync_level) |=>
    bus_rdata[12] == $past(ext_sync_level) && bus_rdata[11:0] == 12'h000 && !bus_rdata[15];
  endproperty
  a_qual: assert property (p_qual) else $error("quality word wrong");
  property p_pair; bus_rd && bus_addr == 8'h0E && $stable(st0) |=> bus_rdata == $past(st0);
  endproperty
  a_pair: assert property (p_pair) else $error("status word not masked");
  property p_doubt; $fell(rst) |=> time_doubtful; endproperty
  a_doubt: assert property (p_doubt) else $error("time not doubtful after reset");
endmodule

bind tve_top tve_mon u_mon (.sys_clk, .rst, .bus_addr, .bus_rd, .bus_rdata, .year_in,
  .month_in, .day_in, .hour_in, .minute_in, .second_in, .msec_in, .ext_sync_level,
  .status_valid_in, .status_bits_in, .time_doubtful);

/* File: testbench/tve_client.sv */
// register client model: reads and writes words on the plain port
// assumes it is the only master; strobes launched right after a rising edge
module tve_client
  import tve_pkg::*;
(
  input wire logic sys_clk,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [DATA_W-1:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] words [0:15];
  // idle bus at time zero
  initial begin
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // one write cycle; data scrambled once released
  task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    bus_wdata <= ~d;
  endtask
  // back-to-back reads; each answer taken at the edge after it stands
  task automatic rd_block(input logic [7:0] a, input int n);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge sys_clk);
      if (i >= 2) words[i-2] = bus_rdata;
      bus_rd <= (i < n);
      bus_addr <= a + 8'(i);
    end
  endtask
  // counter rebuilt from the four words, highest weight first
  function automatic longint cnt_value();
    longint v = 0;
    for (int k = 3; k >= 0; k--) v = v * 64'sh2710 + longint'($signed(words[k]));
    return v;
  endfunction
endmodule

/* File: testbench/tve_top_bench.sv */
// self-checking bench for the timestamp and value encoder
// assumes tve_top at its default counter width and a 100 MHz clock
module tve_top_bench
  import tve_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata;
  logic bus_wr, bus_rd, time_doubtful;
  logic signed [47:0] counter_value = '0;
  logic [11:0] year_in = 12'h07D0;
  logic [3:0] month_in = 4'h1;
  logic [4:0] day_in = 5'h01, hour_in = 5'h00;
  logic [5:0] minute_in = 6'h00, second_in = 6'h00;
  logic [9:0] msec_in = 10'h000;
  logic time_set_pulse = 1'b0, sync_pulse = 1'b0, ext_sync_level = 1'b0;
  logic [31:0] status_valid_in = '0, status_bits_in = '0, seed = 32'hb4b9_8e92;
  bit set_f, sync_f, bad_f;
  int fail_count, check_count;
  // clock and parts
  always #5 sys_clk = ~sys_clk;
  tve_top #(.CNT_W(48)) dut (.sys_clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .counter_value, .year_in, .month_in, .day_in, .hour_in, .minute_in,
    .second_in, .msec_in, .time_set_pulse, .sync_pulse, .ext_sync_level,
    .status_valid_in, .status_bits_in, .time_doubtful);
  tve_client cli (.sys_clk, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata);
  // ****
  // helpers
  // ****
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] exp_word(input int a);
    logic [11:0] yx, ys;
    logic dbt;
    yx = year_in - 12'h076C;
    ys = year_in - 12'h07D0;
    dbt = !set_f | !sync_f | bad_f;
    case (a)
      4: return {dbt, 3'h0, month_in, 3'h0, day_in};
      5: return {yx[7:0], 3'h0, hour_in};
      6: return {2'h0, minute_in, 2'h0, second_in};
      7: return {6'h00, msec_in};
      8: return (year_in < 12'h07D0) ? 16'h0000 : {9'h000, ys[6:0]};
      9: return {4'h0, month_in, 3'h0, day_in};
      10: return {3'h0, hour_in, 2'h0, minute_in};
      11: return 16'(second_in) * 16'h03E8 + 16'(msec_in);
      12: return {1'b0, set_f & !bad_f, sync_f, ext_sync_level, 12'h000};
      13: return status_valid_in[15:0];
      14: return status_bits_in[15:0] & status_valid_in[15:0];
      15: return status_valid_in[31:16];
      16: return status_bits_in[31:16] & status_valid_in[31:16];
      default: return {15'h0, bad_f};
    endcase
  endfunction
  function automatic logic [15:0] digit(input longint v, input int k);
    longint m;
    m = (v < 0) ? -v : v;
    repeat (k) m = m / 64'sh2710;
    m = m % 64'sh2710;
    return 16'((v < 0) ? -m : m);
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task pulse(input bit sel);
    @(posedge sys_clk);
    time_set_pulse <= !sel;
    sync_pulse <= sel;
    @(posedge sys_clk);
    time_set_pulse <= 1'b0;
    sync_pulse <= 1'b0;
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] r;
    longint v, pv;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({15'h0, time_doubtful}, 16'h0001);
    for (int i = 0; i < 20; i++) begin
      r = rnd();
      @(posedge sys_clk);
      year_in <= (i == 0) ? 12'h07BC : (i == 1) ? 12'h07CF : (i == 2) ? 12'h07D0 :
        (i == 3) ? 12'h0833 : 12'h07BC + 12'(r % 120);
      month_in <= 4'(r[3:0] % 12 + 1);
      day_in <= 5'(r[8:4] % 31 + 1);
      hour_in <= 5'(r[13:9] % 24);
      minute_in <= 6'(r[19:14] % 60);
      second_in <= (i == 0) ? 6'h3B : 6'(r[25:20] % 60);
      msec_in <= (i == 0) ? 10'h3E7 : 10'(rnd() % 1000);
      ext_sync_level <= r[31];
      status_valid_in <= rnd();
      status_bits_in <= rnd();
      case (i)
        4: {set_f} = 1'b1;
        6: {sync_f} = 1'b1;
        9: {bad_f, sync_f} = 2'h2;
        11: {bad_f} = 1'b0;
        13: {sync_f} = 1'b1;
        default: ;
      endcase
      if (i == 4 || i == 6 || i == 13) pulse(i != 4);
      if (i == 9 || i == 11) begin
        cli.wr_word(REG_CTRL, (i == 9) ? 16'h0005 : 16'h0000);
        cli.wr_word(8'h30, 16'hFFFF);
        cli.rd_block(8'h30, 1);
        chk(cli.words[0], 16'h0000);
        // clear-sync bit is never stored, so only force_bad reads back
        cli.rd_block(REG_CTRL, 1);
        chk(cli.words[0], {15'h0, bad_f});
      end
      repeat (3) @(posedge sys_clk);
      chk({15'h0, time_doubtful}, {15'h0, !set_f | !sync_f | bad_f});
      cli.rd_block(REG_XTS_BASE, 15);
      for (int k = 0; k < 14; k++) begin
        chk(cli.words[k], exp_word(k + 4));
      end
      // status word: busy bit masked, overflow out of reach at this width
      chk(cli.words[14] & 16'hfffe, {13'h0, sync_f, set_f, 1'b0});
    end
    for (int c = 0; c < 8; c++) begin
      r = rnd();
      case (c)
        0: v = 64'sh0;
        1: v = -64'sh1;
        2: v = 64'sh270F;
        3: v = 64'sh2710;
        4: v = -64'sh05F5_E0FF;
        5: v = 64'sh7FFF_FFFF_FFFF;
        default: v = longint'($signed(r)) * 64'sh101;
      endcase
      // last case freezes the published words, so the earlier value must stay
      if (c == 7) cli.wr_word(REG_CTRL, 16'h0002);
      @(posedge sys_clk);
      counter_value <= 48'(v);
      repeat (450) @(posedge sys_clk);
      cli.rd_block(REG_CNT_BASE, 4);
      if (c < 7) pv = v;
      for (int k = 0; k < 4; k++) chk(cli.words[k], digit(pv, k));
      chk(16'(cli.cnt_value() == pv), 16'h0001);
    end
    finish_test();
  end
endmodule
